// File: verilog/rfc_pkg.sv
// Shared constants and types for the identifier command handler.
package rfc_pkg;
    localparam logic [7:0] CMD_RESET_READY = 8'h26;
    localparam logic [7:0] CMD_WRITE_AFI = 8'h27;
    localparam logic [7:0] CMD_LOCK_AFI = 8'h28;
    localparam logic [7:0] CMD_WRITE_DSFID = 8'h29;
    localparam logic [7:0] CMD_LOCK_DSFID = 8'h2A;
    localparam logic [7:0] ERR_OPTION = 8'h03;
    localparam logic [7:0] ERR_OTHER = 8'h0F;
    localparam logic [7:0] ERR_ALREADY_LOCKED = 8'h11;
    localparam logic [7:0] ERR_LOCKED = 8'h12;
    localparam logic [7:0] ERR_PROGRAM = 8'h13;
    localparam logic [7:0] ERR_LOCK_FAIL = 8'h14;
    localparam logic [7:0] RSP_FLAGS_OK = 8'h00;
    localparam logic [7:0] RSP_FLAGS_ERR = 8'h01;
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam int FLAG_SELECT = 4;
    localparam int FLAG_ADDRESS = 5;
    localparam int FLAG_OPTION = 6;
    localparam int POS_FLAGS = 0;
    localparam int POS_CMD = 1;
    localparam int POS_UID = 2;
    localparam int UID_BYTES = 8;
    localparam int FRAME_BYTES = 11;
    localparam logic [3:0] LEN_BASE = 4'h2;
    localparam logic [3:0] LEN_UID = 4'h8;
    localparam logic [3:0] LEN_PARAM = 4'h1;
    localparam int REF_CLK_PERIOD_NS = 25;
    localparam int NOMINAL_RESPONSE_DELAY_NS = 320900;
    localparam int WRITE_SLOT_NS = 302000;
    localparam int WRITE_SLOTS = 18;
    localparam int RF_WRITE_CYCLE_TIME_NS =
        NOMINAL_RESPONSE_DELAY_NS + WRITE_SLOTS * WRITE_SLOT_NS;
    localparam int RF_WRITE_CYCLES =
        (RF_WRITE_CYCLE_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    localparam int WAIT_CNT_W = 24;
    typedef enum logic [1:0] {
        TAG_READY = 2'b00,
        TAG_SELECTED = 2'b01,
        TAG_QUIET = 2'b10
    } rfc_tag_state_t;
    localparam rfc_tag_state_t TAG_STATE_RESET = TAG_READY;
    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_WRITE = 2'b01,
        CS_RESP = 2'b10
    } rfc_core_state_t;
    typedef enum logic [1:0] {
        LS_RX = 2'b00,
        LS_WAIT = 2'b01,
        LS_TX = 2'b10
    } rfc_link_state_t;
endpackage

// File: verilog/rfc_xsync.sv
// Two-flop synchroniser for one level or toggle.
`timescale 1ns/1ps
`default_nettype none
module rfc_xsync #(
    parameter logic RESET_VAL = 1'b0
) (
    // Destination clock, reset and enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    // Crossing level
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
        end else if (en) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// File: verilog/rfc_link.sv
// Link-side frame capture and response byte sender.
`timescale 1ns/1ps
`default_nettype none
module rfc_link (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic link_rst_b,
    // Request bytes
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_crc_ok,
    // Response bytes
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    // Captured frame toward the core
    output logic [8*rfc_pkg::FRAME_BYTES-1:0] frm_bytes,
    output logic [3:0] frm_len,
    output logic frm_ovf,
    output logic req_tgl,
    // Answer from the core
    input wire logic resp_s,
    input wire logic resp_send,
    input wire logic resp_err,
    input wire logic [7:0] resp_code
);
    logic [7:0] mem [0:rfc_pkg::FRAME_BYTES-1];
    rfc_pkg::rfc_link_state_t ls;
    logic resp_prev;
    wire logic resp_new = resp_s != resp_prev;
    wire logic rx_take = (ls == rfc_pkg::LS_RX) && rx_valid;
    wire logic rx_store = rx_take && (frm_len < 4'(rfc_pkg::FRAME_BYTES));
    wire logic tx_done = tx_valid && tx_ready;

    genvar g;
    for (g = 0; g < rfc_pkg::FRAME_BYTES; g++) begin : g_flat
        assign frm_bytes[8*g +: 8] = mem[g];
    end

    always_ff @(posedge link_clk) begin
        if (rx_store) begin
            mem[frm_len] <= rx_data;
        end
    end

    // The frame stays frozen from the request toggle until the answer,
    // so the core may read it as quasi-static words.
    always_ff @(posedge link_clk) begin
        if (!link_rst_b) begin
            ls <= rfc_pkg::LS_RX;
            frm_len <= 4'h0;
            frm_ovf <= 1'b0;
            req_tgl <= 1'b0;
            resp_prev <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end else begin
            case (ls)
                rfc_pkg::LS_RX: begin
                    if (rx_store) begin
                        frm_len <= frm_len + 4'h1;
                    end else if (rx_take) begin
                        frm_ovf <= 1'b1;
                    end
                    if (rx_take && rx_last && rx_crc_ok) begin
                        req_tgl <= ~req_tgl;
                        ls <= rfc_pkg::LS_WAIT;
                    end else if (rx_take && rx_last) begin
                        frm_len <= 4'h0;
                        frm_ovf <= 1'b0;
                    end
                end
                rfc_pkg::LS_WAIT: begin
                    if (resp_new) begin
                        resp_prev <= resp_s;
                        frm_len <= 4'h0;
                        frm_ovf <= 1'b0;
                        ls <= resp_send ? rfc_pkg::LS_TX : rfc_pkg::LS_RX;
                        tx_valid <= resp_send;
                        tx_data <= resp_err ? rfc_pkg::RSP_FLAGS_ERR
                                            : rfc_pkg::RSP_FLAGS_OK;
                        tx_last <= !resp_err;
                    end
                end
                rfc_pkg::LS_TX: begin
                    if (tx_done && tx_last) begin
                        tx_valid <= 1'b0;
                        tx_last <= 1'b0;
                        ls <= rfc_pkg::LS_RX;
                    end else if (tx_done) begin
                        tx_data <= resp_code;
                        tx_last <= 1'b1;
                    end
                end
                default: ls <= rfc_pkg::LS_RX;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: verilog/rfc_id_cmd.sv
// Reset-to-ready and identifier write/lock command handler.
// Operation
// - Error-free reset-to-ready moves the tag to Ready from any state.
// - Addressed reset-to-ready answers only on own UID, else stays silent.
// - Reset-to-ready frame: flags, 26h, optional UID, CRC.
// - Every request is accepted with or without the UID, except that a quiet tag ignores requests without it and only a Selected tag takes select-flag requests.
// - Success answer is the flags byte and CRC only.
// - Failed reset-to-ready answers error flag plus code 03h or 0Fh.
// - Write-AFI stores the carried byte; the option flag is accepted.
// - Write-AFI frame: flags, 27h, optional UID, AFI byte, CRC.
// - Write-AFI fails with 0Fh, 12h locked or 13h program fault.
// - Lock-AFI freezes the AFI for good; option flag accepted.
// - Lock-AFI frame: flags, 28h, optional UID, CRC.
// - Lock-AFI fails with 0Fh, 11h already locked or 14h.
// - Write-DSFID stores the carried byte; option flag accepted.
// - Write-DSFID frame: flags, 29h, optional UID, DSFID byte, CRC.
// - Write-DSFID fails with 0Fh, 12h locked or 13h.
// - Lock-DSFID freezes the DSFID for good; option flag accepted.
// - Lock-DSFID frame: flags, 2Ah, optional UID, CRC.
// - Lock-DSFID fails with 0Fh, 11h already locked or 14h.
`timescale 1ns/1ps
`default_nettype none
module rfc_id_cmd #(
    parameter int WRITE_CYCLES = rfc_pkg::RF_WRITE_CYCLES
) (
    // Core clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    // Link clock and request bytes, CRC already checked
    input wire logic link_clk,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_crc_ok,
    // Response bytes toward the frame coder
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    // Identity and state from the surrounding tag logic
    input wire logic [63:0] own_uid,
    input wire logic state_load,
    input wire logic [1:0] state_value,
    output var rfc_pkg::rfc_tag_state_t tag_state,
    // Non-volatile identifier storage
    input wire logic [7:0] nvm_afi,
    input wire logic [7:0] nvm_dsfid,
    input wire logic nvm_afi_lock,
    input wire logic nvm_dsfid_lock,
    input wire logic nvm_fault,
    output logic [7:0] afi,
    output logic [7:0] dsfid,
    output logic afi_lock,
    output logic dsfid_lock,
    output logic write_busy
);
    localparam int CW = rfc_pkg::WAIT_CNT_W;
    localparam logic [CW-1:0] WAIT_LOAD = CW'(WRITE_CYCLES - 1);
    localparam logic [CW-1:0] WAIT_FULL = CW'(WRITE_CYCLES);

    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << CW)) begin : g_chk
        $error("WRITE_CYCLES does not fit the wait counter");
    end

    function automatic logic is_either(input logic [7:0] c,
                                       input logic [7:0] a,
                                       input logic [7:0] b);
        is_either = (c == a) || (c == b);
    endfunction

    // Crossing signals
    logic link_rst_b;
    logic req_tgl;
    logic req_s;
    logic resp_s;
    logic [8*rfc_pkg::FRAME_BYTES-1:0] frm_bytes;
    logic [3:0] frm_len;
    logic frm_ovf;

    // Core state
    rfc_pkg::rfc_core_state_t st;
    rfc_pkg::rfc_core_state_t next_st;
    logic req_prev;
    logic resp_tgl;
    logic resp_send;
    logic resp_err;
    logic [7:0] resp_code;
    logic [CW-1:0] wait_cnt;
    logic op_afi;
    logic op_lock;
    logic [7:0] op_data;

    // The link may stop its clock between frames, so its reset is
    // taken from the core reset only when link edges are present.
    rfc_xsync u_rst_sync (
        .clk(link_clk),
        .rst_b(1'b1),
        .en(1'b1),
        .d(rst_b),
        .q(link_rst_b)
    );

    rfc_xsync u_req_sync (
        .clk(ref_clk),
        .rst_b(rst_b),
        .en(ce),
        .d(req_tgl),
        .q(req_s)
    );

    rfc_xsync u_resp_sync (
        .clk(link_clk),
        .rst_b(link_rst_b),
        .en(1'b1),
        .d(resp_tgl),
        .q(resp_s)
    );

    rfc_link u_link (
        .link_clk(link_clk),
        .link_rst_b(link_rst_b),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_last(rx_last),
        .rx_crc_ok(rx_crc_ok),
        .tx_ready(tx_ready),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_last(tx_last),
        .frm_bytes(frm_bytes),
        .frm_len(frm_len),
        .frm_ovf(frm_ovf),
        .req_tgl(req_tgl),
        .resp_s(resp_s),
        .resp_send(resp_send),
        .resp_err(resp_err),
        .resp_code(resp_code)
    );

    // Request decode
    wire logic [7:0] rq_flags = frm_bytes[8*rfc_pkg::POS_FLAGS +: 8];
    wire logic [7:0] rq_cmd = frm_bytes[8*rfc_pkg::POS_CMD +: 8];
    wire logic [63:0] rq_uid =
        frm_bytes[8*rfc_pkg::POS_UID +: 8*rfc_pkg::UID_BYTES];
    wire logic addressed = rq_flags[rfc_pkg::FLAG_ADDRESS];
    wire logic option = rq_flags[rfc_pkg::FLAG_OPTION];
    wire logic sel_flag = rq_flags[rfc_pkg::FLAG_SELECT];
    wire logic is_reset = rq_cmd == rfc_pkg::CMD_RESET_READY;
    wire logic is_write = is_either(rq_cmd, rfc_pkg::CMD_WRITE_AFI,
                                    rfc_pkg::CMD_WRITE_DSFID);
    wire logic is_lock = is_either(rq_cmd, rfc_pkg::CMD_LOCK_AFI,
                                   rfc_pkg::CMD_LOCK_DSFID);
    wire logic is_afi = is_either(rq_cmd, rfc_pkg::CMD_WRITE_AFI,
                                  rfc_pkg::CMD_LOCK_AFI);
    wire logic known = is_reset || is_write || is_lock;
    // Only writes carry a parameter byte, right after the optional UID.
    wire logic [3:0] exp_len = rfc_pkg::LEN_BASE
        + (addressed ? rfc_pkg::LEN_UID : 4'h0)
        + (is_write ? rfc_pkg::LEN_PARAM : 4'h0);
    wire logic [7:0] rq_data = addressed
        ? frm_bytes[8*(rfc_pkg::POS_UID + rfc_pkg::UID_BYTES) +: 8]
        : frm_bytes[8*rfc_pkg::POS_UID +: 8];
    wire logic len_bad = frm_ovf || (frm_len != exp_len);

    // Scope: a quiet tag listens only to addressed requests.
    wire logic uid_hit = !addressed || (rq_uid == own_uid);
    wire logic sel_ok = !sel_flag || (tag_state == rfc_pkg::TAG_SELECTED);
    wire logic quiet_ok = addressed || (tag_state != rfc_pkg::TAG_QUIET);
    wire logic req_new = req_s != req_prev;
    wire logic start = (st == rfc_pkg::CS_IDLE) && req_new;
    wire logic act = start && known && uid_hit && sel_ok && quiet_ok;

    // Early errors are answered at once, without a write cycle.
    wire logic tgt_locked = is_afi ? afi_lock : dsfid_lock;
    wire logic opt_bad = is_reset && option;
    wire logic lock_bad = !is_reset && tgt_locked;
    wire logic pre_fail = len_bad || opt_bad || lock_bad;
    wire logic [7:0] pre_code = len_bad ? rfc_pkg::ERR_OTHER
        : opt_bad ? rfc_pkg::ERR_OPTION
        : (lock_bad && is_write) ? rfc_pkg::ERR_LOCKED
        : lock_bad ? rfc_pkg::ERR_ALREADY_LOCKED
        : rfc_pkg::CODE_NONE;
    wire logic go_write = act && !pre_fail && !is_reset;
    wire logic do_ready = act && !pre_fail && is_reset;

    // End of the write cycle and its outcome.
    wire logic wait_done = (st == rfc_pkg::CS_WRITE) && (wait_cnt == '0);
    wire logic commit = wait_done && !nvm_fault;
    wire logic [7:0] fail_code = op_lock ? rfc_pkg::ERR_LOCK_FAIL
                                         : rfc_pkg::ERR_PROGRAM;

    assign next_st = go_write ? rfc_pkg::CS_WRITE
        : (start || wait_done) ? rfc_pkg::CS_RESP
        : (st == rfc_pkg::CS_RESP) ? rfc_pkg::CS_IDLE
        : st;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= rfc_pkg::CS_IDLE;
            req_prev <= 1'b0;
            resp_tgl <= 1'b0;
            write_busy <= 1'b0;
        end else if (ce) begin
            st <= next_st;
            req_prev <= start ? req_s : req_prev;
            resp_tgl <= resp_tgl ^ (st == rfc_pkg::CS_RESP);
            write_busy <= next_st == rfc_pkg::CS_WRITE;
        end
    end

    // The answer fields are set one cycle before the toggle, so the
    // link sees them settled when the toggle arrives.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            resp_send <= 1'b0;
            resp_err <= 1'b0;
            resp_code <= rfc_pkg::CODE_NONE;
        end else if (ce && start) begin
            resp_send <= act;
            resp_err <= pre_fail;
            resp_code <= pre_code;
        end else if (ce && wait_done) begin
            resp_send <= 1'b1;
            resp_err <= nvm_fault;
            resp_code <= nvm_fault ? fail_code : rfc_pkg::CODE_NONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wait_cnt <= '0;
            op_afi <= 1'b0;
            op_lock <= 1'b0;
            op_data <= 8'h00;
        end else if (ce && go_write) begin
            wait_cnt <= WAIT_LOAD;
            op_afi <= is_afi;
            op_lock <= is_lock;
            op_data <= rq_data;
        end else if (ce && st == rfc_pkg::CS_WRITE && !wait_done) begin
            wait_cnt <= wait_cnt - 1'b1;
        end
    end

    // Storage image: reset reloads it from the non-volatile array.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            afi <= nvm_afi;
            afi_lock <= nvm_afi_lock;
        end else if (ce && commit && op_afi) begin
            afi <= op_lock ? afi : op_data;
            afi_lock <= afi_lock | op_lock;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            dsfid <= nvm_dsfid;
            dsfid_lock <= nvm_dsfid_lock;
        end else if (ce && commit && !op_afi) begin
            dsfid <= op_lock ? dsfid : op_data;
            dsfid_lock <= dsfid_lock | op_lock;
        end
    end

    // Our reset-to-ready wins over a state load in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tag_state <= rfc_pkg::TAG_STATE_RESET;
        end else if (ce && do_ready) begin
            tag_state <= rfc_pkg::TAG_READY;
        end else if (ce && state_load) begin
            tag_state <= rfc_pkg::rfc_tag_state_t'(state_value);
        end
    end

    // Checks
    logic [CW-1:0] wr_age;

    always_ff @(posedge ref_clk) begin
        if (!rst_b || (ce && !write_busy)) begin
            wr_age <= '0;
        end else if (ce) begin
            wr_age <= wr_age + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk iff ce);
    endclocking
    default disable iff (!rst_b);

    a_ready_after_reset: assert property (
        do_ready |=> tag_state == rfc_pkg::TAG_READY && resp_send
            && !resp_err ##1 resp_tgl != $past(resp_tgl))
        else $error("reset to ready did not reach Ready");

    a_uid_miss_silent: assert property (
        start && addressed && !uid_hit
            |=> !resp_send ##1 resp_tgl != $past(resp_tgl))
        else $error("foreign UID was answered");

    a_option_reset: assert property (
        act && opt_bad && !len_bad
            |=> resp_err && resp_code == rfc_pkg::ERR_OPTION)
        else $error("option on reset to ready not refused");

    a_locked_write: assert property (
        act && is_write && tgt_locked && !len_bad
            |=> resp_err && resp_code == rfc_pkg::ERR_LOCKED
            && $stable(afi) && $stable(dsfid) && !write_busy)
        else $error("write to locked value not refused");

    a_relock_refused: assert property (
        act && is_lock && tgt_locked && !len_bad
            |=> resp_err && resp_code == rfc_pkg::ERR_ALREADY_LOCKED)
        else $error("second lock not refused");

    a_write_hold: assert property (
        $fell(write_busy) |-> wr_age == WAIT_FULL && resp_send
            ##1 resp_tgl != $past(resp_tgl))
        else $error("write cycle length wrong");

    a_afi_commit: assert property (
        $fell(write_busy) && op_afi && !op_lock && !resp_err
            |-> afi == op_data)
        else $error("AFI not stored");

    a_dsfid_commit: assert property (
        $fell(write_busy) && !op_afi && !op_lock && !resp_err
            |-> dsfid == op_data)
        else $error("DSFID not stored");

    a_afi_lock_kept: assert property (
        afi_lock |=> afi_lock && $stable(afi))
        else $error("locked AFI changed");

    a_dsfid_lock_kept: assert property (
        dsfid_lock |=> dsfid_lock && $stable(dsfid))
        else $error("locked DSFID changed");

    a_fail_code: assert property (
        $fell(write_busy) && resp_err |-> resp_code == (op_lock
            ? rfc_pkg::ERR_LOCK_FAIL : rfc_pkg::ERR_PROGRAM))
        else $error("wrong programming fault code");

    c_reset_ok: cover property (do_ready ##2 st == rfc_pkg::CS_IDLE);
    c_afi_written: cover property (
        $fell(write_busy) && op_afi && !resp_err);
    c_lock_fault: cover property ($fell(write_busy) && op_lock && resp_err);
    c_uid_miss: cover property (start && addressed && !uid_hit);
endmodule
`default_nettype wire

// File: verif/rfc_reader.sv
// Reader model: sends request bytes on the link and collects the answer.
`timescale 1ns/1ps
`default_nettype none
module rfc_reader (
    // Keeps the link clock running around reset
    input wire logic keep,
    // Request side
    output logic link_clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_crc_ok,
    // Answer side
    output logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last
);
    logic run;
    // The link clock stands still between frames, low.
    initial begin
        run = 1'b0;
        link_clk = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'hA5;
        rx_last = 1'b0;
        rx_crc_ok = 1'b0;
        tx_ready = 1'b0;
        #3.1;
        forever begin
            #62.5;
            if (run || keep || link_clk) link_clk = ~link_clk;
        end
    end
    task automatic xfer(input logic [7:0] f[$], input int slow,
                        output logic [7:0] r[$]);
        int n;
        r = {};
        run = 1'b1;
        foreach (f[i]) begin
            @(negedge link_clk);
            rx_valid = 1'b1;
            rx_data = f[i];
            rx_last = (i == f.size() - 1);
            rx_crc_ok = 1'b1;
        end
        @(negedge link_clk);
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_crc_ok = 1'b0;
        rx_data = ~rx_data;
        n = 0;
        // No new request until the answer is over or surely absent.
        while (n < 60) begin
            n++;
            tx_ready = (n % (slow + 1)) == 0;
            @(posedge link_clk);
            if (tx_valid && tx_ready) begin
                r.push_back(tx_data);
                if (tx_last) n = 60;
            end
            @(negedge link_clk);
        end
        tx_ready = 1'b0;
        repeat (6) @(negedge link_clk);
        run = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: verif/rfc_id_cmd_tb.sv
// Self-checking bench for the identifier command handler.
`timescale 1ns/1ps
`default_nettype none
module rfc_id_cmd_tb;
    typedef logic [7:0] rfc_bq_t[$];
    logic ref_clk = 1'b0;
    logic rst_b;
    logic keep;
    logic link_clk, rx_valid, rx_last, rx_crc_ok, tx_ready, tx_valid;
    logic tx_last, state_load, nvm_fault, afi_lock, dsfid_lock, write_busy;
    logic [7:0] rx_data, tx_data, afi, dsfid, nvm_afi, nvm_dsfid;
    logic [1:0] state_value;
    logic [63:0] uid;
    rfc_pkg::rfc_tag_state_t tag_state;
    logic [31:0] seed = 32'h000101BA;
    int n_fail = 0;
    int comparisons = 0;
    int m_v[2], m_lk[2], m_st, m_flt, bc;
    logic [7:0] ops[10] = '{8'h27, 8'h29, 8'h29, 8'h2A, 8'h28, 8'h2A,
                            8'h27, 8'h29, 8'h28, 8'h2A};
    logic flt[10] = '{0, 0, 1, 1, 0, 0, 0, 0, 0, 0};
    rfc_id_cmd #(.WRITE_CYCLES(20)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1), .link_clk(link_clk),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_crc_ok(rx_crc_ok), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .own_uid(uid),
        .state_load(state_load), .state_value(state_value),
        .tag_state(tag_state), .nvm_afi(nvm_afi), .nvm_dsfid(nvm_dsfid),
        .nvm_afi_lock(1'b0), .nvm_dsfid_lock(1'b0), .nvm_fault(nvm_fault),
        .afi(afi), .dsfid(dsfid), .afi_lock(afi_lock),
        .dsfid_lock(dsfid_lock), .write_busy(write_busy));
    rfc_reader i_rdr (
        .keep(keep), .link_clk(link_clk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_crc_ok(rx_crc_ok),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last));
    always #12.5 ref_clk = ~ref_clk;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask
    task automatic model(input rfc_bq_t f, output rfc_bq_t e);
        logic [63:0] u;
        int k, wr;
        e = {};
        u = 64'h0;
        k = f[1] > 8'h28;
        wr = f[1] == 8'h27 || f[1] == 8'h29;
        for (int i = 9; i >= 2; i--) u = {u[55:0], f[i]};
        // Foreign UID, select flag off Selected, or Quiet and unaddressed.
        if ((f[0][5] && u !== uid) || (f[0][4] && m_st != 1)
            || (!f[0][5] && m_st == 2)) return;
        if (f.size() != 2 + 8 * f[0][5] + wr) e = {8'h01, 8'h0F};
        else if (f[1] == 8'h26 && f[0][6]) e = {8'h01, 8'h03};
        else if (f[1] == 8'h26) begin
            m_st = 0;
            e = {8'h00};
        end else if (m_lk[k]) e = {8'h01, wr ? 8'h12 : 8'h11};
        else if (m_flt) e = {8'h01, wr ? 8'h13 : 8'h14};
        else begin
            if (wr) m_v[k] = f[f.size() - 1];
            else m_lk[k] = 1;
            e = {8'h00};
        end
    endtask
    task automatic run(input logic [7:0] fl, input logic [7:0] c,
                       input logic [63:0] u, input logic np);
        rfc_bq_t f, e, r;
        f = {fl, c};
        if (fl[5]) for (int i = 0; i < 8; i++) f.push_back(u[8*i+:8]);
        if (np) f.push_back(rnd());
        model(f, e);
        i_rdr.xfer(f, int'(rnd() % 3), r);
        cmp(r.size(), e.size());
        foreach (e[i]) cmp(r[i], e[i]);
        cmp(tag_state, m_st);
        cmp(afi, m_v[0]);
        cmp(dsfid, m_v[1]);
        cmp(afi_lock, m_lk[0]);
        cmp(dsfid_lock, m_lk[1]);
        $display("frame %0h done at %0t", c, $time);
    endtask
    task automatic st(input logic [1:0] v);
        @(negedge ref_clk);
        state_load = 1'b1;
        state_value = v;
        @(negedge ref_clk);
        state_load = 1'b0;
        m_st = v;
    endtask
    // Link edges keep running so the link side sees the reset as well.
    task automatic rst_pulse;
        keep = 1'b1;
        rst_b = 1'b0;
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (40) @(negedge ref_clk);
        keep = 1'b0;
        m_v = '{nvm_afi, nvm_dsfid};
        m_lk = '{0, 0};
        m_st = 0;
    endtask
    // An answer must never overlap the write cycle.
    always @(posedge ref_clk) begin
        if (write_busy) bc <= bc + 1;
        else if (bc != 0) begin
            cmp(bc, 20);
            bc <= 0;
        end
        if (write_busy) cmp(tx_valid, 0);
    end
    task close_out;
        $display("compared %0d, failed %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        close_out();
    end
    initial begin
        state_load = 1'b0;
        state_value = 2'b00;
        nvm_fault = 1'b0;
        nvm_afi = rnd();
        nvm_dsfid = rnd();
        uid = 64'h0;
        repeat (8) uid = {uid[55:0], rnd()};
        m_flt = 0;
        bc = 0;
        rst_pulse();
        st(2'b01);
        run(8'h00, 8'h26, uid, 1'b0);
        st(2'b01);
        run(8'h20, 8'h26, ~uid, 1'b0);
        run(8'h20, 8'h26, uid, 1'b0);
        run(8'h40, 8'h26, uid, 1'b0);
        run(8'h00, 8'h27, uid, 1'b0);
        run(8'h00, 8'h28, uid, 1'b1);
        st(2'b10);
        run(8'h00, 8'h26, uid, 1'b0);
        run(8'h30, 8'h26, uid, 1'b0);
        run(8'h20, 8'h26, uid, 1'b0);
        foreach (ops[i]) begin
            @(negedge ref_clk);
            nvm_fault = flt[i];
            m_flt = flt[i];
            run(rnd() & 8'h60, ops[i], uid, ops[i][0]);
        end
        // A second reset reloads the storage image from the array.
        @(negedge ref_clk);
        rst_pulse();
        run(8'h20, 8'h27, uid, 1'b1);
        close_out();
    end
endmodule
`default_nettype wire
